/* File: core/gpi_ports.sv */
// three 8-bit io ports with pin-group interrupt request logic
`timescale 1ns/1ns
module gpi_ports (
	ref_clk,
	reset_n,
	io_addr,
	io_wr,
	io_rd,
	io_wdata,
	io_rdata,
	io_rvalid,
	pa_in,
	pb_in,
	pc_in,
	pa_out,
	pb_out,
	pc_out,
	pa_oe_n,
	pb_oe_n,
	pc_oe_n,
	pa_pull_up,
	pb_pull_up,
	pa_die,
	pb_die,
	pc_die,
	pa_wake_en,
	pb_wake_en,
	pc_wake_en,
	external_reset_input,
	external_reset_sel,
	int_enable,
	int_request
);
	input wire logic ref_clk;
	input wire logic reset_n;
	input wire logic [5:0] io_addr;
	input wire logic io_wr;
	input wire logic io_rd;
	input wire logic [7:0] io_wdata;
	output logic [7:0] io_rdata;
	output logic io_rvalid;
	input wire logic [7:0] pa_in;
	input wire logic [7:0] pb_in;
	input wire logic [7:0] pc_in;
	output logic [7:0] pa_out;
	output logic [7:0] pb_out;
	output logic [7:0] pc_out;
	output logic [7:0] pa_oe_n;
	output logic [7:0] pb_oe_n;
	output logic [7:0] pc_oe_n;
	output logic [7:0] pa_pull_up;
	output logic [7:0] pb_pull_up;
	output logic [7:0] pa_die;
	output logic [7:0] pb_die;
	output logic [7:0] pc_die;
	output logic [7:0] pa_wake_en;
	output logic [7:0] pb_wake_en;
	output logic [7:0] pc_wake_en;
	output logic external_reset_input;
	output logic external_reset_sel;
	output logic [1:0] int_enable;
	output logic [1:0] int_request;

	gpi_pkg::gpi_state_s st_q;
	gpi_pkg::gpi_state_s st_d;
	logic [7:0] pa_dig;
	logic [7:0] pb_dig;
	logic [1:0] grp_now;
	logic [1:0] grp_hit;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// data read: input pins return sampled level, outputs the latch
	function automatic logic [7:0] gpi_rd_data(input logic [7:0] latch, input logic [7:0] dir,
		input logic [7:0] pins);
		gpi_rd_data = (latch & dir) | (pins & ~dir); // [RULE12]
	endfunction : gpi_rd_data

	// edge detector per edge select code
	function automatic logic gpi_edge_hit(input logic [1:0] sel, input logic prev,
		input logic now);
		gpi_edge_hit = 1'b0;
		unique case (sel)
			gpi_pkg::GPI_EDGE_BOTH: gpi_edge_hit = prev ^ now;
			gpi_pkg::GPI_EDGE_RISE: gpi_edge_hit = ~prev & now;
			gpi_pkg::GPI_EDGE_FALL: gpi_edge_hit = prev & ~now;
			default: gpi_edge_hit = 1'b0; // reserved code triggers nothing
		endcase
	endfunction : gpi_edge_hit

	// ----------------------------------------
	// pin group sampling
	// ----------------------------------------
	// disabled digital inputs read as zero and cannot wake or trigger
	assign pa_dig = pa_in & st_q.pa.die; // [RULE4] [RULE5]
	assign pb_dig = pb_in & st_q.pb.die; // [RULE5]
	assign grp_now[gpi_pkg::GRP1_BIT] = pb_dig[0] | pa_dig[4] | pa_dig[3] | pb_dig[6];
	assign grp_now[gpi_pkg::GRP0_BIT] = pa_dig[0] | pb_dig[5] | pa_dig[2] | pa_dig[7];
	assign grp_hit[gpi_pkg::GRP1_BIT] = gpi_edge_hit(st_q.edge1,
		st_q.grp_prev[gpi_pkg::GRP1_BIT], grp_now[gpi_pkg::GRP1_BIT]); // [RULE8]
	assign grp_hit[gpi_pkg::GRP0_BIT] = gpi_edge_hit(st_q.edge0,
		st_q.grp_prev[gpi_pkg::GRP0_BIT], grp_now[gpi_pkg::GRP0_BIT]); // [RULE9]

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		st_d = st_q;
		st_d.rvalid = io_rd;
		st_d.grp_prev = grp_now;
		if (io_wr) begin
			unique case (io_addr)
				gpi_pkg::CLK_MODE_OFS: st_d.rst_pin_sel = io_wdata[gpi_pkg::RST_PIN_SEL_BIT]; // [RULE6]
				gpi_pkg::INT_ENABLE_OFS: st_d.int_en = io_wdata[1:0]; // [RULE11]
				gpi_pkg::INT_REQUEST_OFS: st_d.int_req = io_wdata[1:0]; // [RULE10]
				gpi_pkg::EDGE_SELECT_OFS: begin
					st_d.edge1 = io_wdata[gpi_pkg::GRP1_EDGE_LO +: 2]; // [RULE8]
					st_d.edge0 = io_wdata[gpi_pkg::GRP0_EDGE_LO +: 2]; // [RULE9]
				end
				gpi_pkg::PA_DIE_OFS: st_d.pa.die = io_wdata; // [RULE4]
				gpi_pkg::PB_DIE_OFS: st_d.pb.die = io_wdata; // [RULE4]
				gpi_pkg::PC_DIE_OFS: st_d.pc.die = io_wdata; // [RULE4]
				gpi_pkg::PA_DATA_OFS: st_d.pa.data = io_wdata; // [RULE1]
				gpi_pkg::PA_DIR_OFS: st_d.pa.dir = io_wdata; // [RULE2] [RULE7]
				gpi_pkg::PA_PU_OFS: st_d.pa.pull_up = io_wdata; // [RULE3]
				gpi_pkg::PB_DATA_OFS: st_d.pb.data = io_wdata; // [RULE1]
				gpi_pkg::PB_DIR_OFS: st_d.pb.dir = io_wdata; // [RULE2]
				gpi_pkg::PB_PU_OFS: st_d.pb.pull_up = io_wdata; // [RULE3]
				gpi_pkg::PC_DATA_OFS: st_d.pc.data = io_wdata; // [RULE1]
				gpi_pkg::PC_DIR_OFS: st_d.pc.dir = io_wdata; // [RULE2]
				default: st_d.rvalid = io_rd;
			endcase
		end
		// hardware set wins over a software clear in the same cycle
		st_d.int_req = st_d.int_req | grp_hit; // [RULE10]
		// read mux; write-only and unmapped offsets read zero
		st_d.rdata = gpi_pkg::ZERO_RST;
		if (io_rd) begin
			unique case (io_addr)
				gpi_pkg::CLK_MODE_OFS: st_d.rdata = {7'h00, st_q.rst_pin_sel};
				gpi_pkg::INT_ENABLE_OFS: st_d.rdata = {6'h00, st_q.int_en};
				gpi_pkg::INT_REQUEST_OFS: st_d.rdata = {6'h00, st_q.int_req};
				gpi_pkg::PA_DATA_OFS: st_d.rdata = gpi_rd_data(st_q.pa.data, st_q.pa.dir,
					pa_dig); // [RULE12]
				gpi_pkg::PA_DIR_OFS: st_d.rdata = st_q.pa.dir;
				gpi_pkg::PA_PU_OFS: st_d.rdata = st_q.pa.pull_up;
				gpi_pkg::PB_DATA_OFS: st_d.rdata = gpi_rd_data(st_q.pb.data, st_q.pb.dir,
					pb_dig); // [RULE12]
				gpi_pkg::PB_DIR_OFS: st_d.rdata = st_q.pb.dir;
				gpi_pkg::PB_PU_OFS: st_d.rdata = st_q.pb.pull_up;
				gpi_pkg::PC_DATA_OFS: st_d.rdata = gpi_rd_data(st_q.pc.data, st_q.pc.dir,
					pc_in & st_q.pc.die); // [RULE12]
				gpi_pkg::PC_DIR_OFS: st_d.rdata = st_q.pc.dir;
				default: st_d.rdata = gpi_pkg::ZERO_RST;
			endcase
		end
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			st_q.pa <= '{gpi_pkg::ZERO_RST, gpi_pkg::ZERO_RST, gpi_pkg::ZERO_RST,
				gpi_pkg::DIE_RST}; // [RULE1] [RULE2] [RULE3] [RULE4]
			st_q.pb <= '{gpi_pkg::ZERO_RST, gpi_pkg::ZERO_RST, gpi_pkg::ZERO_RST,
				gpi_pkg::DIE_RST};
			st_q.pc <= '{gpi_pkg::ZERO_RST, gpi_pkg::ZERO_RST, gpi_pkg::ZERO_RST,
				gpi_pkg::DIE_RST};
			st_q.rst_pin_sel <= 1'b0; // [RULE6]
			st_q.int_en <= 2'h0; // [RULE11]
			st_q.int_req <= 2'h0;
			st_q.edge1 <= gpi_pkg::EDGE_RST;
			st_q.edge0 <= gpi_pkg::EDGE_RST;
			st_q.grp_prev <= 2'h0;
			st_q.rdata <= gpi_pkg::ZERO_RST;
			st_q.rvalid <= 1'b0;
		end else begin
			st_q <= st_d;
		end
	end

	// ----------------------------------------
	// pin drive and outputs
	// ----------------------------------------
	// port a pin 5 released from io duty when it serves as reset input
	always_comb begin
		pa_out = st_q.pa.data; // [RULE12]
		pa_oe_n = ~st_q.pa.dir; // [RULE2] [RULE7]
		if (st_q.rst_pin_sel) begin
			pa_oe_n[gpi_pkg::ALT_RESET_PIN] = 1'b1; // [RULE6]
		end
	end
	assign pb_out = st_q.pb.data;
	assign pc_out = st_q.pc.data;
	assign pb_oe_n = ~st_q.pb.dir;
	assign pc_oe_n = ~st_q.pc.dir;
	assign pa_pull_up = st_q.pa.pull_up & ~st_q.pa.dir; // [RULE3]
	assign pb_pull_up = st_q.pb.pull_up & ~st_q.pb.dir; // [RULE3]
	assign pa_die = st_q.pa.die;
	assign pb_die = st_q.pb.die;
	assign pc_die = st_q.pc.die;
	assign pa_wake_en = st_q.pa.die & ~st_q.pa.dir; // [RULE5]
	assign pb_wake_en = st_q.pb.die & ~st_q.pb.dir; // [RULE5]
	assign pc_wake_en = st_q.pc.die & ~st_q.pc.dir; // [RULE5]
	assign external_reset_sel = st_q.rst_pin_sel;
	assign external_reset_input = st_q.rst_pin_sel & pa_in[gpi_pkg::ALT_RESET_PIN]; // [RULE6]
	assign int_enable = st_q.int_en; // [RULE11]
	assign int_request = st_q.int_req & st_q.int_en; // [RULE11]
	assign io_rdata = st_q.rdata;
	assign io_rvalid = st_q.rvalid;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	data_write_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RULE1]
		io_wr && io_addr == gpi_pkg::PB_DATA_OFS |=> pb_out == $past(io_wdata))
		else $error("port b data not written");
	dir_drive_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RULE2]
		pc_oe_n == ~st_q.pc.dir && pb_oe_n == ~st_q.pb.dir)
		else $error("direction does not steer enable");
	pull_input_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RULE3]
		(pa_pull_up & st_q.pa.dir) == 8'h00)
		else $error("pull-up active on output pin");
	die_write_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RULE4]
		io_wr && io_addr == gpi_pkg::PC_DIE_OFS |=> pc_die == $past(io_wdata))
		else $error("digital input enable not written");
	wake_gate_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RULE5]
		(pa_wake_en & ~pa_die) == 8'h00)
		else $error("wake on disabled pin");
	alt_reset_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RULE6]
		external_reset_sel |-> pa_oe_n[gpi_pkg::ALT_RESET_PIN])
		else $error("reset pin driven as output");
	grp1_rise_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RULE8]
		st_q.edge1 == gpi_pkg::GPI_EDGE_RISE && $rose(grp_now[1]) |=> st_q.int_req[1])
		else $error("group one rise missed");
	grp0_fall_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RULE9]
		st_q.edge0 == gpi_pkg::GPI_EDGE_FALL && $fell(grp_now[0]) |=> st_q.int_req[0])
		else $error("group zero fall missed");
	req_sticky_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RULE10]
		st_q.int_req[0] && !(io_wr && io_addr == gpi_pkg::INT_REQUEST_OFS) |=> st_q.int_req[0])
		else $error("request cleared without software");
	req_gate_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // [RULE11]
		!st_q.int_en[1] |-> !int_request[1])
		else $error("disabled group reaches request");
endmodule : gpi_ports

/* File: shared/gpi_pkg.sv */
// package of constants and carriers for the gpio port block
// Notes on behaviour
// RULE1 - each of ports a, b and c has an 8-bit read/write data register that resets to zero.
// RULE2 - each port has an 8-bit direction register, 1 for output, reset to all inputs.
// RULE3 - ports a and b have per-pin pull-up enables that act only on input pins, reset zero.
// RULE4 - each port has a write-only digital-input enable, 0 disables the pin, reset all ones.
// RULE5 - a pin whose digital input is disabled is ignored as a wake-up source.
// RULE6 - clock mode bit 0 turns port a pin 5 from ordinary io into the external reset input.
// RULE7 - port a pin 5 may be input or output while it is ordinary io.
// RULE8 - edge select bits 3-2 pick both, rising or falling edges for the first pin group.
// RULE9 - edge select bits 1-0 pick both, rising or falling edges for the second pin group.
// RULE10 - a pin-group request bit is set by the selected edge and cleared only by software.
// RULE11 - enable bit 1 gates the first group and bit 0 the second, both reset to zero.
// RULE12 - output pins follow the data register and reads of data return input pin levels; the code returns the data latch for output pins.
package gpi_pkg;
	// ----------------------------------------
	// io space offsets
	// ----------------------------------------
	localparam logic [5:0] CLK_MODE_OFS = 6'h03;
	localparam logic [5:0] INT_ENABLE_OFS = 6'h04;
	localparam logic [5:0] INT_REQUEST_OFS = 6'h05;
	localparam logic [5:0] EDGE_SELECT_OFS = 6'h0c;
	localparam logic [5:0] PA_DIE_OFS = 6'h0d;
	localparam logic [5:0] PB_DIE_OFS = 6'h0e;
	localparam logic [5:0] PC_DIE_OFS = 6'h0f;
	localparam logic [5:0] PA_DATA_OFS = 6'h10;
	localparam logic [5:0] PA_DIR_OFS = 6'h11;
	localparam logic [5:0] PA_PU_OFS = 6'h12;
	localparam logic [5:0] PB_DATA_OFS = 6'h13;
	localparam logic [5:0] PB_DIR_OFS = 6'h14;
	localparam logic [5:0] PB_PU_OFS = 6'h15;
	localparam logic [5:0] PC_DATA_OFS = 6'h16;
	localparam logic [5:0] PC_DIR_OFS = 6'h17;
	// ----------------------------------------
	// reset values and field positions
	// ----------------------------------------
	localparam logic [7:0] ZERO_RST = 8'h00;
	localparam logic [7:0] DIE_RST = 8'hff;
	localparam logic [1:0] EDGE_RST = 2'h0;
	localparam int RST_PIN_SEL_BIT = 0;
	localparam int ALT_RESET_PIN = 5;
	localparam int GRP1_BIT = 1;
	localparam int GRP0_BIT = 0;
	localparam int GRP1_EDGE_LO = 2;
	localparam int GRP0_EDGE_LO = 0;
	// pins feeding each group: group1 pb0 pa4 pa3 pb6, group0 pa0 pb5 pa2 pa7
	localparam int PORT_W = 8;
	// ----------------------------------------
	// edge select codes
	// ----------------------------------------
	typedef enum logic [1:0] {
		GPI_EDGE_BOTH = 2'h0,
		GPI_EDGE_RISE = 2'h1,
		GPI_EDGE_FALL = 2'h2,
		GPI_EDGE_RSVD = 2'h3
	} gpi_edge_e;
	// ----------------------------------------
	// carriers
	// ----------------------------------------
	typedef struct packed {
		logic [7:0] data;
		logic [7:0] dir;
		logic [7:0] pull_up;
		logic [7:0] die;
	} gpi_port_s;
	typedef struct packed {
		gpi_port_s pa;
		gpi_port_s pb;
		gpi_port_s pc;
		logic rst_pin_sel;
		logic [1:0] int_en;
		logic [1:0] int_req;
		logic [1:0] edge1;
		logic [1:0] edge0;
		logic [1:0] grp_prev;
		logic [7:0] rdata;
		logic rvalid;
	} gpi_state_s;
endpackage : gpi_pkg

/* File: tb/gpi_board.sv */
// board-side model of the pins of the three ports
`timescale 1ns/1ns
module gpi_board (
	ref_clk,
	drv_en,
	drv_val,
	out_v,
	oe_n,
	pull_up,
	pin
);
	input wire logic ref_clk;
	input wire logic [23:0] drv_en;
	input wire logic [23:0] drv_val;
	input wire logic [23:0] out_v;
	input wire logic [23:0] oe_n;
	input wire logic [23:0] pull_up;
	output logic [23:0] pin;
	logic [23:0] float_q = 24'h5a5a5a;
	// lines nobody holds wander every cycle
	always @(negedge ref_clk) begin
		float_q <= ~float_q;
	end
	// device drive wins, then board drive, then pull-up
	always_comb begin
		for (int i = 0; i < 24; i++) begin
			if (!oe_n[i]) begin
				pin[i] = out_v[i];
			end else if (drv_en[i]) begin
				pin[i] = drv_val[i];
			end else if (pull_up[i]) begin
				pin[i] = 1'b1;
			end else begin
				pin[i] = float_q[i];
			end
		end
	end
endmodule : gpi_board

/* File: tb/test_gpio_ports_with_pin_interrupts.sv */
// self-checking bench for the gpio port block
`timescale 1ns/1ns
module test_gpio_ports_with_pin_interrupts;
	logic ref_clk = 1'b0;
	logic reset_n = 1'b0;
	logic [5:0] io_addr = 6'h00;
	logic io_wr = 1'b0;
	logic io_rd = 1'b0;
	logic [7:0] io_wdata = 8'h00;
	logic [7:0] io_rdata;
	logic io_rvalid, ext_in, ext_sel;
	logic [1:0] int_enable, int_request;
	logic [23:0] drv_en = 24'hffffff;
	logic [23:0] drv_val = 24'h000000;
	logic [23:0] pins, outs, oe_n, wake, die, pull;
	logic [15:0] seed = 16'h4fae;
	int n_errors = 0;
	int total_checks = 0;
	int g1[4] = '{8, 4, 3, 14};
	int g0[4] = '{0, 13, 2, 7};
	assign pull[23:16] = 8'h00;
	gpi_ports i_gpi_ports (.ref_clk(ref_clk), .reset_n(reset_n), .io_addr(io_addr),
		.io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
		.io_rvalid(io_rvalid), .pa_in(pins[7:0]), .pb_in(pins[15:8]), .pc_in(pins[23:16]),
		.pa_out(outs[7:0]), .pb_out(outs[15:8]), .pc_out(outs[23:16]),
		.pa_oe_n(oe_n[7:0]), .pb_oe_n(oe_n[15:8]), .pc_oe_n(oe_n[23:16]),
		.pa_pull_up(pull[7:0]), .pb_pull_up(pull[15:8]),
		.pa_die(die[7:0]), .pb_die(die[15:8]), .pc_die(die[23:16]),
		.pa_wake_en(wake[7:0]), .pb_wake_en(wake[15:8]), .pc_wake_en(wake[23:16]),
		.external_reset_input(ext_in), .external_reset_sel(ext_sel),
		.int_enable(int_enable), .int_request(int_request));
	gpi_board i_gpi_board (.ref_clk(ref_clk), .drv_en(drv_en), .drv_val(drv_val),
		.out_v(outs), .oe_n(oe_n), .pull_up(pull), .pin(pins));
	// 10 MHz clock
	always #50 ref_clk = ~ref_clk;
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic wr(input logic [5:0] a, input logic [7:0] v);
		@(negedge ref_clk);
		io_addr = a;
		io_wdata = v;
		io_wr = 1'b1;
		@(negedge ref_clk);
		io_wr = 1'b0;
	endtask : wr
	task automatic rdc(input logic [5:0] a, input logic [7:0] e);
		@(negedge ref_clk);
		io_addr = a;
		io_rd = 1'b1;
		@(negedge ref_clk);
		io_rd = 1'b0;
		check({7'h00, io_rvalid}, 8'h01);
		check(io_rdata, e);
	endtask : rdc
	task automatic end_sim();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : end_sim
	function automatic logic [7:0] rnd();
		seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
		return seed[7:0];
	endfunction : rnd
	function automatic logic [7:0] exp_rd(input logic [7:0] dt, dr, pn, en);
		return (dt & dr) | (pn & en & ~dr);
	endfunction : exp_rd
	// main sequence
	initial begin
		logic [7:0] dt, dr, en, pu, v;
		logic [1:0] e;
		repeat (8) @(negedge ref_clk);
		reset_n = 1'b1;
		for (int a = 16; a < 24; a++) rdc(6'(a), 8'h00);
		for (int p = 0; p < 3; p++) begin
			check(die[p*8+:8], 8'hff);
			rdc(6'h0d + 6'(p), 8'h00);
		end
		check({6'h00, int_enable}, 8'h00);
		check({7'h00, ext_sel}, 8'h00);
		rdc(6'h0c, 8'h00);
		rdc(6'h3f, 8'h00);
		// random port set-ups, first pass with pull-ups holding idle pins
		for (int it = 0; it < 8; it++) begin
			for (int p = 0; p < 3; p++) begin
				dt = rnd();
				dr = (it == 0) ? 8'h00 : rnd();
				en = (it == 0) ? 8'hff : rnd();
				v = rnd();
				pu = (p == 2) ? 8'h00 : (it == 0) ? 8'hff : rnd();
				drv_en[p*8+:8] = (it == 0 && p < 2) ? 8'h00 : 8'hff;
				drv_val[p*8+:8] = v;
				wr(6'h10 + 6'(3 * p), dt);
				wr(6'h11 + 6'(3 * p), dr);
				if (p < 2) wr(6'h12 + 6'(3 * p), pu);
				wr(6'h0d + 6'(p), en);
				check(outs[p*8+:8], dt);
				check(oe_n[p*8+:8], ~dr);
				check(pull[p*8+:8], pu & ~dr);
				check(die[p*8+:8], en);
				check(wake[p*8+:8], en & ~dr);
				v = drv_en[p*8] ? v : 8'hff;
				rdc(6'h10 + 6'(3 * p), exp_rd(dt, dr, v, en));
			end
		end
		// port a pin 5 as external reset input
		drv_en = 24'hffffff;
		drv_val = 24'h000020;
		wr(6'h11, 8'h00);
		wr(6'h03, 8'h01);
		check({7'h00, ext_sel}, 8'h01);
		check({7'h00, ext_in}, 8'h01);
		rdc(6'h03, 8'h01);
		wr(6'h03, 8'h00);
		check({7'h00, ext_in}, 8'h00);
		// pin-group edges, one code and one pin pair per pass
		wr(6'h14, 8'h00);
		wr(6'h0d, 8'hff);
		wr(6'h0e, 8'hff);
		drv_val = 24'h000000;
		for (int c = 0; c < 4; c++) begin
			wr(6'h0c, {4'h0, 2'(c), 2'(c)});
			wr(6'h04, {6'h00, 2'(c)});
			wr(6'h05, 8'h00);
			drv_val[g1[c]] = 1'b1;
			drv_val[g0[c]] = 1'b1;
			repeat (3) @(negedge ref_clk);
			e = (c < 2) ? 2'h3 : 2'h0;
			rdc(6'h05, {6'h00, e});
			check({6'h00, int_request}, {6'h00, e & 2'(c)});
			check({6'h00, int_enable}, 8'(c));
			drv_val = 24'h000000;
			repeat (3) @(negedge ref_clk);
			rdc(6'h05, {6'h00, e | ((c == 0 || c == 2) ? 2'h3 : 2'h0)});
		end
		// disabled digital input gives no edge
		wr(6'h0c, 8'h00);
		wr(6'h05, 8'h00);
		wr(6'h0d, 8'h00);
		drv_val[0] = 1'b1;
		repeat (3) @(negedge ref_clk);
		rdc(6'h05, 8'h00);
		end_sim();
	end
	// cut a hang short
	initial begin
		#3000000;
		n_errors++;
		end_sim();
	end
endmodule : test_gpio_ports_with_pin_interrupts
